// ==== timer_pkg.sv ====
// shared constants for the timer/counter block
package timer_pkg;

  localparam int unsigned ADDR_W = 10;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_RUN_CONTROL = 8'h88;
  localparam logic [7:0] IDX_TIMER_MODE_CONTROL = 8'h89;
  localparam logic [7:0] IDX_TIMER0_LOW_BYTE = 8'h8A;
  localparam logic [7:0] IDX_TIMER1_LOW_BYTE = 8'h8B;
  localparam logic [7:0] IDX_TIMER0_HIGH_BYTE = 8'h8C;
  localparam logic [7:0] IDX_TIMER1_HIGH_BYTE = 8'h8D;
  localparam logic [7:0] IDX_THIRD_TIMER_CONTROL = 8'hC8;
  localparam logic [7:0] IDX_THIRD_TIMER_MODE = 8'hC9;
  localparam logic [7:0] IDX_RELOAD_CAPTURE_LOW = 8'hCA;
  localparam logic [7:0] IDX_RELOAD_CAPTURE_HIGH = 8'hCB;
  localparam logic [7:0] IDX_THIRD_TIMER_LOW_BYTE = 8'hCC;
  localparam logic [7:0] IDX_THIRD_TIMER_HIGH_BYTE = 8'hCD;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hD0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hD1;

  // timer_mode_control fields
  localparam int MODE_SECOND_TIMER_GATING = 7;
  localparam int MODE_SRC1 = 6;
  localparam int MODE_FIRST_TIMER_GATING = 3;
  localparam int MODE_SRC0 = 2;

  // run control fields
  localparam int RUN_FIRST = 0;
  localparam int RUN_SECOND = 1;

  // third_timer_control fields
  localparam int T2C_OVF = 7;
  localparam int T2C_EXT = 6;
  localparam int T2C_RUN = 2;
  localparam int T2C_SRC = 1;
  localparam int T2C_CPRL = 0;
  localparam logic [7:0] T2C_STORED = 8'hC7;

  // third_timer_mode field
  localparam int T2M_DOWN_COUNT_ENABLE = 0;

  // interrupt status bits
  localparam int IRQ_T0 = 0;
  localparam int IRQ_T1 = 1;
  localparam int IRQ_T2 = 2;
  localparam int IRQ_W = 3;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;

  // cycles of clk per count tick
  localparam int T2_DIV = 6;
  localparam int BASE_DIV_DEFAULT = 12;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } timer_mode_t;

endpackage

// ==== basic_timer.sv ====
// one basic timer: two count bytes and the four counting modes
module basic_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic inc_low,
  input wire logic inc_high,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  input wire timer_pkg::timer_mode_t mode,
  output logic [7:0] low_q,
  output logic [7:0] high_q,
  output logic ovf_low,
  output logic ovf_high
);

  logic [7:0] low_d;
  logic [7:0] high_d;

  always_comb
  begin
    low_d = low_q;
    high_d = high_q;
    ovf_low = 1'b0;
    ovf_high = 1'b0;
    case (mode)
      timer_pkg::MODE_13BIT:
        if (inc_low)
        begin
          // upper three low bits are left alone and carry no meaning
          low_d[4:0] = low_q[4:0] + 5'h01;
          if (low_q[4:0] == 5'h1F)
          begin
            high_d = high_q + 8'h01;
            ovf_low = (high_q == 8'hFF);
          end
        end
      timer_pkg::MODE_16BIT:
        if (inc_low)
        begin
          {high_d, low_d} = {high_q, low_q} + 16'h0001;
          ovf_low = ({high_q, low_q} == timer_pkg::COUNT_TOP);
        end
      timer_pkg::MODE_RELOAD:
        if (inc_low)
        begin
          if (low_q == 8'hFF)
          begin
            low_d = high_q;
            ovf_low = 1'b1;
          end
          else
            low_d = low_q + 8'h01;
        end
      default:
      begin
        if (inc_low)
        begin
          low_d = low_q + 8'h01;
          ovf_low = (low_q == 8'hFF);
        end
        if (inc_high)
        begin
          high_d = high_q + 8'h01;
          ovf_high = (high_q == 8'hFF);
        end
      end
    endcase
    // a software write wins over a count in the same cycle
    if (wr_low)
      low_d = wdata;
    if (wr_high)
      high_d = wdata;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      low_q <= timer_pkg::RST_BYTE;
      high_q <= timer_pkg::RST_BYTE;
    end
    else
    begin
      low_q <= low_d;
      high_q <= high_d;
    end
  end

  property p_prescale_carry;
    @(posedge clk) disable iff (rst)
    (mode == timer_pkg::MODE_13BIT && inc_low && low_q[4:0] == 5'h1F && !wr_low && !wr_high)
      |=> (high_q == 8'($past(high_q) + 8'h01)) && (low_q[4:0] == 5'h00);
  endproperty
  a_prescale_carry: assert property (p_prescale_carry)
    else $error("prescaler wrap did not step the high byte");

  property p_cascade;
    @(posedge clk) disable iff (rst)
    (mode == timer_pkg::MODE_16BIT && inc_low && low_q == 8'hFF && !wr_low && !wr_high)
      |=> (low_q == 8'h00) && (high_q == 8'($past(high_q) + 8'h01));
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("16-bit mode did not carry into the high byte");

  property p_reload;
    @(posedge clk) disable iff (rst)
    (mode == timer_pkg::MODE_RELOAD && inc_low && low_q == 8'hFF && !wr_low && !wr_high)
      ##0 ovf_low |=> (low_q == $past(high_q)) && $stable(high_q);
  endproperty
  a_reload: assert property (p_reload)
    else $error("auto-reload did not load the low byte from the high byte");

  c_reload: cover property (@(posedge clk) disable iff (rst)
    mode == timer_pkg::MODE_RELOAD && ovf_low);

endmodule

// ==== timer_counters.sv ====
// timer/counter block: two basic timers, an up/down third timer, register slave
//
// The Avalon-MM interface to the registers is this design's own decision.
module timer_counters #(
  parameter int BASE_DIV = timer_pkg::BASE_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [timer_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic first_gate_pin,
  input wire logic second_gate_pin,
  input wire logic first_count_pin,
  input wire logic second_count_pin,
  input wire logic third_count_pin,
  input wire logic direction_pin
);

  localparam int DIV_W = (BASE_DIV > 1) ? $clog2(BASE_DIV) : 1;
  localparam int T2_W = $clog2(timer_pkg::T2_DIV);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then the request is taken

  logic [7:0] timer_mode_control_q;
  logic [1:0] run_q;
  logic [7:0] third_timer_control_q;
  logic down_count_enable_q;
  logic [15:0] reload_capture_q;
  logic [15:0] t2_cnt_q;
  logic [timer_pkg::IRQ_W-1:0] irq_status_q;
  logic [timer_pkg::IRQ_W-1:0] irq_mask_q;
  logic [7:0] t0_low;
  logic [7:0] t0_high;
  logic [7:0] t1_low;
  logic [7:0] t1_high;
  logic waitrequest_q;
  logic [31:0] readdata_q;
  logic irq_q;
  logic wr_en;
  logic [7:0] wd;
  logic [31:0] rd_val;

  assign waitrequest = waitrequest_q;
  assign readdata = readdata_q;
  assign irq = irq_q;
  assign wr_en = write && !waitrequest_q && byteenable[0];
  assign wd = writedata[7:0];

  function automatic logic hit(input logic [timer_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  logic wr_mode;
  logic wr_run;
  logic wr_t0_low;
  logic wr_t0_high;
  logic wr_t1_low;
  logic wr_t1_high;
  logic wr_t2_ctrl;
  logic wr_t2_mode;
  logic wr_rcap_low;
  logic wr_rcap_high;
  logic wr_t2_low;
  logic wr_t2_high;
  logic wr_status;
  logic wr_mask;

  assign wr_mode = wr_en && hit(address, timer_pkg::IDX_TIMER_MODE_CONTROL);
  assign wr_run = wr_en && hit(address, timer_pkg::IDX_RUN_CONTROL);
  assign wr_t0_low = wr_en && hit(address, timer_pkg::IDX_TIMER0_LOW_BYTE);
  assign wr_t0_high = wr_en && hit(address, timer_pkg::IDX_TIMER0_HIGH_BYTE);
  assign wr_t1_low = wr_en && hit(address, timer_pkg::IDX_TIMER1_LOW_BYTE);
  assign wr_t1_high = wr_en && hit(address, timer_pkg::IDX_TIMER1_HIGH_BYTE);
  assign wr_t2_ctrl = wr_en && hit(address, timer_pkg::IDX_THIRD_TIMER_CONTROL);
  assign wr_t2_mode = wr_en && hit(address, timer_pkg::IDX_THIRD_TIMER_MODE);
  assign wr_rcap_low = wr_en && hit(address, timer_pkg::IDX_RELOAD_CAPTURE_LOW);
  assign wr_rcap_high = wr_en && hit(address, timer_pkg::IDX_RELOAD_CAPTURE_HIGH);
  assign wr_t2_low = wr_en && hit(address, timer_pkg::IDX_THIRD_TIMER_LOW_BYTE);
  assign wr_t2_high = wr_en && hit(address, timer_pkg::IDX_THIRD_TIMER_HIGH_BYTE);
  assign wr_status = wr_en && hit(address, timer_pkg::IDX_IRQ_STATUS);
  assign wr_mask = wr_en && hit(address, timer_pkg::IDX_IRQ_MASK);

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (hit(address, timer_pkg::IDX_TIMER_MODE_CONTROL))
      rd_val[7:0] = timer_mode_control_q;
    else if (hit(address, timer_pkg::IDX_RUN_CONTROL))
      rd_val[1:0] = run_q;
    else if (hit(address, timer_pkg::IDX_TIMER0_LOW_BYTE))
      rd_val[7:0] = t0_low;
    else if (hit(address, timer_pkg::IDX_TIMER0_HIGH_BYTE))
      rd_val[7:0] = t0_high;
    else if (hit(address, timer_pkg::IDX_TIMER1_LOW_BYTE))
      rd_val[7:0] = t1_low;
    else if (hit(address, timer_pkg::IDX_TIMER1_HIGH_BYTE))
      rd_val[7:0] = t1_high;
    else if (hit(address, timer_pkg::IDX_THIRD_TIMER_CONTROL))
      rd_val[7:0] = third_timer_control_q;
    else if (hit(address, timer_pkg::IDX_THIRD_TIMER_MODE))
      rd_val[0] = down_count_enable_q;
    else if (hit(address, timer_pkg::IDX_RELOAD_CAPTURE_LOW))
      rd_val[7:0] = reload_capture_q[7:0];
    else if (hit(address, timer_pkg::IDX_RELOAD_CAPTURE_HIGH))
      rd_val[7:0] = reload_capture_q[15:8];
    else if (hit(address, timer_pkg::IDX_THIRD_TIMER_LOW_BYTE))
      rd_val[7:0] = t2_cnt_q[7:0];
    else if (hit(address, timer_pkg::IDX_THIRD_TIMER_HIGH_BYTE))
      rd_val[7:0] = t2_cnt_q[15:8];
    else if (hit(address, timer_pkg::IDX_IRQ_STATUS))
      rd_val[timer_pkg::IRQ_W-1:0] = irq_status_q;
    else if (hit(address, timer_pkg::IDX_IRQ_MASK))
      rd_val[timer_pkg::IRQ_W-1:0] = irq_mask_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h0000_0000;
    end
    else
    begin
      waitrequest_q <= !((read || write) && waitrequest_q);
      if (read && waitrequest_q)
        readdata_q <= rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      timer_mode_control_q <= timer_pkg::RST_BYTE;
      run_q <= 2'b00;
      down_count_enable_q <= 1'b0;
      reload_capture_q <= timer_pkg::RST_WORD;
      irq_mask_q <= '0;
    end
    else
    begin
      if (wr_mode)
        timer_mode_control_q <= wd;
      if (wr_run)
        run_q <= wd[1:0];
      if (wr_t2_mode)
        down_count_enable_q <= wd[timer_pkg::T2M_DOWN_COUNT_ENABLE];
      if (wr_rcap_low)
        reload_capture_q[7:0] <= wd;
      if (wr_rcap_high)
        reload_capture_q[15:8] <= wd;
      if (wr_mask)
        irq_mask_q <= wd[timer_pkg::IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count sources

  logic [DIV_W-1:0] base_div_q;
  logic base_tick;
  logic [T2_W-1:0] t2_div_q;
  logic t2_div_tick;
  logic [2:0] pin_prev_q;
  logic fall0;
  logic fall1;
  logic fall2;

  assign base_tick = (base_div_q == DIV_W'(BASE_DIV - 1));
  assign t2_div_tick = (t2_div_q == T2_W'(timer_pkg::T2_DIV - 1));
  // pins arrive synchronous, so one stage of history is enough for edges
  assign fall0 = pin_prev_q[0] && !first_count_pin;
  assign fall1 = pin_prev_q[1] && !second_count_pin;
  assign fall2 = pin_prev_q[2] && !third_count_pin;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      base_div_q <= '0;
      t2_div_q <= '0;
      pin_prev_q <= 3'b000;
    end
    else
    begin
      base_div_q <= base_tick ? '0 : DIV_W'(base_div_q + 1'b1);
      t2_div_q <= t2_div_tick ? '0 : T2_W'(t2_div_q + 1'b1);
      pin_prev_q <= {third_count_pin, second_count_pin, first_count_pin};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // basic timers

  timer_pkg::timer_mode_t mode0;
  timer_pkg::timer_mode_t mode1;
  logic split0;
  logic en0;
  logic en1;
  logic inc0;
  logic inc0_high;
  logic inc1;
  logic t0_ovf_low;
  logic t0_ovf_high;
  logic t1_ovf_low;
  logic ev_t0;
  logic ev_t1;

  assign mode0 = timer_pkg::timer_mode_t'(timer_mode_control_q[1:0]);
  assign mode1 = timer_pkg::timer_mode_t'(timer_mode_control_q[5:4]);
  assign split0 = (mode0 == timer_pkg::MODE_SPLIT);
  assign en0 = run_q[timer_pkg::RUN_FIRST]
    && (!timer_mode_control_q[timer_pkg::MODE_FIRST_TIMER_GATING] || first_gate_pin);
  assign en1 = run_q[timer_pkg::RUN_SECOND]
    && (!timer_mode_control_q[timer_pkg::MODE_SECOND_TIMER_GATING] || second_gate_pin);
  assign inc0 = en0 && (timer_mode_control_q[timer_pkg::MODE_SRC0] ? fall0 : base_tick);
  // split high byte always counts the internal clock under the second run bit
  assign inc0_high = split0 && run_q[timer_pkg::RUN_SECOND] && base_tick;
  // second timer in its split code is halted and keeps its count
  assign inc1 = (mode1 != timer_pkg::MODE_SPLIT) && en1
    && (timer_mode_control_q[timer_pkg::MODE_SRC1] ? fall1 : base_tick);
  assign ev_t0 = t0_ovf_low;
  assign ev_t1 = split0 ? t0_ovf_high : t1_ovf_low;

  basic_timer u_timer0 (
    .clk(clk),
    .rst(rst),
    .inc_low(inc0),
    .inc_high(inc0_high),
    .wr_low(wr_t0_low),
    .wr_high(wr_t0_high),
    .wdata(wd),
    .mode(mode0),
    .low_q(t0_low),
    .high_q(t0_high),
    .ovf_low(t0_ovf_low),
    .ovf_high(t0_ovf_high)
  );

  basic_timer u_timer1 (
    .clk(clk),
    .rst(rst),
    .inc_low(inc1),
    .inc_high(1'b0),
    .wr_low(wr_t1_low),
    .wr_high(wr_t1_high),
    .wdata(wd),
    .mode(mode1),
    .low_q(t1_low),
    .high_q(t1_high),
    .ovf_low(t1_ovf_low),
    .ovf_high()
  );

  ////////////////////////////////////////////////////////////////////////////
  // third timer: 16-bit auto-reload, up or down

  logic t2_inc;
  logic t2_up;
  logic t2_evt;
  logic [15:0] t2_cnt_d;
  logic [7:0] t2_ctrl_base;

  assign t2_inc = third_timer_control_q[timer_pkg::T2C_RUN]
    && (third_timer_control_q[timer_pkg::T2C_SRC] ? fall2 : t2_div_tick);
  assign t2_up = !down_count_enable_q || direction_pin;

  always_comb
  begin
    t2_cnt_d = t2_cnt_q;
    t2_evt = 1'b0;
    if (t2_inc)
    begin
      if (t2_up)
      begin
        if (t2_cnt_q == timer_pkg::COUNT_TOP)
        begin
          t2_cnt_d = reload_capture_q;
          t2_evt = 1'b1;
        end
        else
          t2_cnt_d = t2_cnt_q + 16'h0001;
      end
      else if (t2_cnt_q == reload_capture_q)
      begin
        t2_cnt_d = timer_pkg::COUNT_TOP;
        t2_evt = 1'b1;
      end
      else
        t2_cnt_d = t2_cnt_q - 16'h0001;
    end
    if (wr_t2_low)
      t2_cnt_d[7:0] = wd;
    if (wr_t2_high)
      t2_cnt_d[15:8] = wd;
  end

  // software may clear the flags, but a same-cycle wrap still lands
  assign t2_ctrl_base = wr_t2_ctrl ? (wd & timer_pkg::T2C_STORED) : third_timer_control_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      t2_cnt_q <= timer_pkg::RST_WORD;
      third_timer_control_q <= timer_pkg::RST_BYTE;
    end
    else
    begin
      t2_cnt_q <= t2_cnt_d;
      third_timer_control_q <= t2_ctrl_base;
      third_timer_control_q[timer_pkg::T2C_OVF] <=
        t2_ctrl_base[timer_pkg::T2C_OVF] || t2_evt;
      third_timer_control_q[timer_pkg::T2C_EXT] <=
        t2_ctrl_base[timer_pkg::T2C_EXT] ^ (t2_evt && down_count_enable_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, write one to clear, set wins

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_status_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      // the external flag toggle is kept out of the status on purpose
      irq_status_q <= (irq_status_q & ~(wr_status ? wd[timer_pkg::IRQ_W-1:0] : '0))
        | {t2_evt, ev_t1, ev_t0};
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_gate_hold;
    @(posedge clk) disable iff (rst)
    (timer_mode_control_q[timer_pkg::MODE_FIRST_TIMER_GATING] && !first_gate_pin && !wr_t0_low)
      |=> $stable(t0_low);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("gated timer0 low byte moved while its gate pin was low");

  property p_src_edge;
    @(posedge clk) disable iff (rst)
    (timer_mode_control_q[timer_pkg::MODE_SRC0] && !fall0 && !wr_t0_low)
      |=> $stable(t0_low);
  endproperty
  a_src_edge: assert property (p_src_edge)
    else $error("counter-mode timer0 moved without a falling pin edge");

  property p_split_flag;
    @(posedge clk) disable iff (rst)
    (split0 && inc0_high && t0_high == 8'hFF && !wr_t0_high)
      |=> irq_status_q[timer_pkg::IRQ_T1];
  endproperty
  a_split_flag: assert property (p_split_flag)
    else $error("split high byte wrap did not set the second timer flag");

  property p_t2_stop;
    @(posedge clk) disable iff (rst)
    (!third_timer_control_q[timer_pkg::T2C_RUN] && !wr_t2_low && !wr_t2_high)
      |=> $stable(t2_cnt_q);
  endproperty
  a_t2_stop: assert property (p_t2_stop)
    else $error("third timer moved while stopped");

  property p_t2_div;
    @(posedge clk) disable iff (rst)
    t2_div_tick |=> !t2_div_tick [*5] ##1 t2_div_tick;
  endproperty
  a_t2_div: assert property (p_t2_div)
    else $error("third timer internal tick is not every six cycles");

  property p_t2_ovf;
    @(posedge clk) disable iff (rst)
    (t2_inc && t2_up && t2_cnt_q == timer_pkg::COUNT_TOP && !wr_t2_low && !wr_t2_high)
      |=> (t2_cnt_q == $past(reload_capture_q)) && third_timer_control_q[timer_pkg::T2C_OVF]
        && irq_status_q[timer_pkg::IRQ_T2];
  endproperty
  a_t2_ovf: assert property (p_t2_ovf)
    else $error("third timer overflow did not reload and flag");

  property p_t2_udf;
    @(posedge clk) disable iff (rst)
    (t2_inc && !t2_up && t2_cnt_q == reload_capture_q && !wr_t2_low && !wr_t2_high)
      |=> (t2_cnt_q == timer_pkg::COUNT_TOP) && third_timer_control_q[timer_pkg::T2C_OVF];
  endproperty
  a_t2_udf: assert property (p_t2_udf)
    else $error("third timer underflow did not load FFFFh and flag");

  property p_ext_toggle;
    @(posedge clk) disable iff (rst)
    (!wr_t2_ctrl && !(t2_evt && down_count_enable_q))
      |=> $stable(third_timer_control_q[timer_pkg::T2C_EXT]);
  endproperty
  a_ext_toggle: assert property (p_ext_toggle)
    else $error("external flag changed without an up/down wrap");

  property p_up_only;
    @(posedge clk) disable iff (rst)
    (t2_inc && !down_count_enable_q && t2_cnt_q != timer_pkg::COUNT_TOP
      && !wr_t2_low && !wr_t2_high)
      |=> t2_cnt_q == 16'($past(t2_cnt_q) + 16'h0001);
  endproperty
  a_up_only: assert property (p_up_only)
    else $error("third timer did not count up with down count disabled");

  c_split_wrap: cover property (@(posedge clk) disable iff (rst) split0 && t0_ovf_high);
  c_t2_under: cover property (@(posedge clk) disable iff (rst) t2_evt && !t2_up);
  c_t2_over: cover property (@(posedge clk) disable iff (rst) t2_evt && t2_up);

endmodule

// ==== pin_model.sv ====
// model of the external count, gate and direction lines
module pin_model (
  input wire logic clk,
  output logic [2:0] count_pins,
  output logic [1:0] gate_pins,
  output logic dir_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    count_pins = 3'b111;
    gate_pins = 2'b00;
    dir_pin = 1'b1;
  end
  // count lines idle high, so only the driven low pulses make falling edges
  task automatic pulse(input int which, input int n);
    repeat (n)
    begin
      @(posedge clk);
      count_pins[which] <= 1'b0;
      repeat (2 + n) @(posedge clk);
      count_pins[which] <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic lines(input logic [1:0] g, input logic d);
    @(posedge clk);
    gate_pins <= g;
    dir_pin <= d;
  endtask
endmodule

// ==== timer_counters_tb.sv ====
// self-checking bench for the timer/counter block
module timer_counters_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, read, write, waitrequest, irq, dir_pin;
  logic [9:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [2:0] count_pins;
  logic [1:0] gate_pins;
  logic [31:0] exp_q[$];
  logic [7:0] rnd;
  int miscompares, comparisons, cycles, seed;
  timer_counters #(.BASE_DIV(2)) dut (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .first_gate_pin(gate_pins[0]),
    .second_gate_pin(gate_pins[1]), .first_count_pin(count_pins[0]),
    .second_count_pin(count_pins[1]), .third_count_pin(count_pins[2]),
    .direction_pin(dir_pin));
  pin_model pins (.clk(clk), .count_pins(count_pins), .gate_pins(gate_pins), .dir_pin(dir_pin));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] e, input logic [31:0] a);
    comparisons++;
    if (a !== e)
    begin
      miscompares++;
      $display("Error at %0t: expected %h got %h", $time, e, a);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= {24'h0, d};
    byteenable <= 4'hF;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, idx, 8'h00);
  endtask
  // irq is registered one cycle behind status and mask
  task automatic chk_irq(input logic e);
    repeat (3) @(posedge clk);
    cmp({31'h0, e}, {31'h0, irq});
  endtask
  always @(posedge clk)
    if (read === 1'b1 && waitrequest === 1'b0)
      cmp(exp_q.pop_front(), readdata);
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 48917;
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 10'h000;
    writedata = 32'h0;
    byteenable = 4'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(8'h89, 8'h00);
    rd(8'h00, 8'h00);
    rnd = 8'($random(seed));
    wr(8'h8D, rnd);
    rd(8'h8D, rnd);
    wr(8'h89, 8'h05);
    wr(8'h88, 8'h01);
    pins.pulse(0, 3);
    rd(8'h8A, 8'h03);
    wr(8'h89, 8'h0D);
    pins.pulse(0, 2);
    rd(8'h8A, 8'h03);
    pins.lines(2'b01, 1'b1);
    pins.pulse(0, 1);
    rd(8'h8A, 8'h04);
    wr(8'h89, 8'h06);
    wr(8'h8C, 8'hFE);
    wr(8'h8A, 8'hFE);
    pins.pulse(0, 2);
    rd(8'h8A, 8'hFE);
    rd(8'h8C, 8'hFE);
    rd(8'hD0, 8'h01);
    chk_irq(1'b0);
    wr(8'hD1, 8'h01);
    chk_irq(1'b1);
    wr(8'hD0, 8'h01);
    chk_irq(1'b0);
    // direction low while down counting is off must still count up
    pins.lines(2'b01, 1'b0);
    wr(8'hCB, 8'h12);
    wr(8'hCA, 8'h34);
    wr(8'hCD, 8'hFF);
    wr(8'hCC, 8'hFE);
    wr(8'hC8, 8'h06);
    pins.pulse(2, 2);
    rd(8'hCC, 8'h34);
    rd(8'hCD, 8'h12);
    rd(8'hC8, 8'h86);
    rd(8'hD0, 8'h04);
    chk_irq(1'b0);
    wr(8'hD1, 8'h05);
    chk_irq(1'b1);
    wr(8'hC8, 8'h06);
    wr(8'hD0, 8'h04);
    wr(8'hC9, 8'h01);
    wr(8'hCD, 8'h12);
    wr(8'hCC, 8'h35);
    pins.pulse(2, 2);
    rd(8'hCD, 8'hFF);
    rd(8'hC8, 8'hC6);
    rd(8'hD0, 8'h04);
    // 13-bit mode on pin edges: prescaler wrap steps the high byte
    wr(8'h89, 8'h04);
    wr(8'h8A, 8'h1F);
    wr(8'h8C, 8'h05);
    pins.pulse(0, 1);
    rd(8'h8A, 8'h00);
    rd(8'h8C, 8'h06);
    // split first timer, second timer halted; high byte runs on the second run bit
    wr(8'h8B, 8'h55);
    wr(8'h89, 8'h37);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h03);
    wr(8'h88, 8'h01);
    rd(8'h8B, 8'h55);
    rd(8'hD0, 8'h06);
    chk_irq(1'b1);
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule
